// ---- src/reset_cause_and_nmi_control.sv ----
// Reset source merge, reset cause flags and NMI control with APB access
// Summary of operation
// - All reset sources merge into master reset
// - Any reset sets a cause flag; the counted reset sets the watchdog bit 4
// - Bit 10 flags deep sleep, POR clears
// - Bit 9 flags configuration mismatch reset
// - Bit 7 flags master clear pin reset
// - Bit 6 flags software reset
// - Bit 4 flags watchdog time-out
// - Bits 3 and 2 flag sleep, idle
// - Bits 1, 0 flag brown-out, power-on
// - Bit 24 watchdog NMI, write starts counter
// - Bit 23 write of one raises NMI
// - Bit 19 general NMI, also key 0x4E
// - Bit 18 flags low-voltage detect NMI
// - Bit 17 clock fail, write causes NMI
// - Bit 16 sleep watchdog wake, write NMI
// - Bits 15:0 hold counter reload value
// - Zero reload resets immediately on watchdog or clock-fail NMI
// - Clearing both watchdog and clock-fail NMIs aborts counted reset
// - Clear, set, invert aliases at +4,+8,+c
// - Reset values are fixed: flags 0x3, NMI zero
//
// The placing of the registers and register access over APB were decided locally.
module reset_cause_and_nmi_control (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_on_event,
    input  wire logic        brownout_event,
    input  wire logic        master_clear_pin,
    input  wire logic        watchdog_reset_source,
    input  wire logic        config_mismatch_event,
    input  wire logic        deep_sleep_event,
    input  wire logic        sleep_wake_event,
    input  wire logic        idle_wake_event,
    input  wire logic        watchdog_nmi_event,
    input  wire logic        sleep_watchdog_event,
    input  wire logic        general_nmi_event,
    input  wire logic        voltage_detect_event,
    input  wire logic        clock_fail_monitor,
    input  wire logic        nmi_key_write,
    input  wire logic [7:0]  nmi_key_field,
    input  wire logic [31:0] configuration_fuses,
    output logic             system_master_reset,
    output logic             nmi_out
);
    logic [31:0] reset_cause_flags_reg;
    logic [31:0] nmi_reg;
    logic [31:0] reset_cause_flags_next;
    logic [31:0] nmi_next;
    logic [1:0]  pin_sync_reg;
    logic        pin_prev_reg;
    logic        pin_fall;
    logic [1:0]  unlock_reg;
    logic        sw_reset_reg;
    logic        fuse_reg_nmi_en_reg;
    logic        fire;
    logic        cnt_busy;
    logic        cnt_start;
    logic        cnt_pending;
    logic        acc;
    logic        wr;
    logic [7:0]  base;
    logic [1:0]  op;
    logic        sw_nmi_wr;
    logic        key_hit;
    logic        nmi_q;
    logic [31:0] nmi_wr_val;

    assign acc  = psel && penable;
    assign wr   = acc && pwrite;
    assign base = {paddr[7:4], 4'h0};
    assign op   = paddr[3:2];

    // Pin crosses two flip-flops before any logic looks at it
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_sync_reg <= 2'b11;
            pin_prev_reg <= 1'b1;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], master_clear_pin};
            pin_prev_reg <= pin_sync_reg[1];
        end
    end
    assign pin_fall = pin_prev_reg && !pin_sync_reg[1];

    // Fuse bit 0 captured after release; lets the counted NMI reset reach the output
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fuse_reg_nmi_en_reg <= 1'b0;
        end else begin
            fuse_reg_nmi_en_reg <= configuration_fuses[0];
        end
    end

    // Write alias: plain, clear, set or invert
    function automatic logic [31:0] apply(input logic [31:0] cur,
                                          input logic [1:0]  o,
                                          input logic [31:0] d);
        unique case (o)
            2'd0: apply = d;
            2'd1: apply = cur & ~d;
            2'd2: apply = cur | d;
            2'd3: apply = cur ^ d;
        endcase
    endfunction

    // Unlock by two key writes in a row to the trigger address
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            unlock_reg   <= 2'b00;
            sw_reset_reg <= 1'b0;
        end else begin
            sw_reset_reg <= 1'b0;
            if (wr && base == rst_pkg::SOFTWARE_RESET_TRIGGER_OFS) begin
                if (pwdata == rst_pkg::UNLOCK_KEY1) begin
                    unlock_reg <= 2'b01;
                end else if (pwdata == rst_pkg::UNLOCK_KEY2 && unlock_reg == 2'b01) begin
                    unlock_reg <= 2'b10;
                end else begin
                    // Locked writes are dropped
                    if (unlock_reg == 2'b10 && pwdata[0]) begin
                        sw_reset_reg <= 1'b1;
                    end
                    unlock_reg <= 2'b00;
                end
            end
        end
    end

    // Cause flags: bus write first, hardware sets win afterwards
    always_comb begin
        reset_cause_flags_next = reset_cause_flags_reg;
        if (wr && base == rst_pkg::RESET_CAUSE_FLAGS_OFS) begin
            reset_cause_flags_next = apply(reset_cause_flags_reg, op, pwdata) & rst_pkg::RESET_CAUSE_FLAGS_MASK;
        end
        if (deep_sleep_event)      reset_cause_flags_next[rst_pkg::B_DEEP_SLEEP] = 1'b1;
        if (config_mismatch_event) reset_cause_flags_next[rst_pkg::B_CFG_MISM]   = 1'b1;
        if (pin_fall)              reset_cause_flags_next[rst_pkg::B_PIN_RST]    = 1'b1;
        if (sw_reset_reg)          reset_cause_flags_next[rst_pkg::B_SW_RST]     = 1'b1;
        if (watchdog_reset_source) reset_cause_flags_next[rst_pkg::B_WDT_RST]    = 1'b1;
        if (sleep_wake_event)      reset_cause_flags_next[rst_pkg::B_SLEEP]      = 1'b1;
        if (idle_wake_event)       reset_cause_flags_next[rst_pkg::B_IDLE]       = 1'b1;
        if (brownout_event)        reset_cause_flags_next[rst_pkg::B_BROWNOUT]   = 1'b1;
        if (fire)                  reset_cause_flags_next[rst_pkg::B_WDT_RST]    = 1'b1;
    end

    // Power-on restores the fixed pattern, deep sleep cleared
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reset_cause_flags_reg <= rst_pkg::RESET_CAUSE_FLAGS_RESET;
        end else if (power_on_event) begin
            reset_cause_flags_reg <= rst_pkg::RESET_CAUSE_FLAGS_RESET;
        end else begin
            reset_cause_flags_reg <= reset_cause_flags_next;
        end
    end

    assign key_hit   = nmi_key_write && nmi_key_field == rst_pkg::NMI_KEY_VALUE;
    assign sw_nmi_wr = wr && base == rst_pkg::NMI_OFS;
    assign nmi_wr_val = apply(nmi_reg, op, pwdata);

    always_comb begin
        nmi_next = nmi_reg;
        if (sw_nmi_wr) begin
            nmi_next = nmi_wr_val & rst_pkg::NMI_MASK;
        end
        // Trigger bit never stays set; its effect is the NMI pulse
        nmi_next[rst_pkg::B_SW_NMI] = 1'b0;
        if (watchdog_nmi_event)   nmi_next[rst_pkg::B_WDT_NMI]   = 1'b1;
        if (general_nmi_event || key_hit) nmi_next[rst_pkg::B_GEN_NMI] = 1'b1;
        if (voltage_detect_event) nmi_next[rst_pkg::B_VOLT_NMI]  = 1'b1;
        if (clock_fail_monitor)   nmi_next[rst_pkg::B_CLK_FAIL]  = 1'b1;
        if (sleep_watchdog_event) nmi_next[rst_pkg::B_SLEEP_WDT] = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            nmi_reg <= rst_pkg::NMI_RESET;
        end else begin
            nmi_reg <= nmi_next;
        end
    end

    // Rising edge of any cause bit, or software trigger, raises the NMI
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= (|(nmi_next[24:16] & ~nmi_reg[24:16]))
                   || (sw_nmi_wr && nmi_wr_val[rst_pkg::B_SW_NMI]);
        end
    end

    // Only watchdog and clock-fail causes run the counter
    assign cnt_pending = nmi_reg[rst_pkg::B_WDT_NMI] || nmi_reg[rst_pkg::B_CLK_FAIL];
    assign cnt_start   = cnt_pending && fuse_reg_nmi_en_reg;

    nmi_reset_counter u_cnt (
        .mclk    (mclk),
        .rstn    (rstn),
        .start   (cnt_start),
        .pending (cnt_pending),
        .reload  (nmi_reg[15:0]),
        .fire    (fire),
        .busy    (cnt_busy)
    );

    // Master reset merges power-on, brown-out, pin, software, watchdog, mismatch and counted resets
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            system_master_reset <= 1'b1;
            nmi_out             <= 1'b0;
        end else begin
            system_master_reset <= power_on_event || brownout_event || pin_fall
                                 || sw_reset_reg || watchdog_reset_source
                                 || config_mismatch_event || fire;
            nmi_out             <= nmi_q;
        end
    end

    // APB: zero wait, unmapped offsets answer with error
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            prdata  <= rst_pkg::RSV_VALUE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= rst_pkg::RSV_VALUE;
            if (psel && !penable) begin
                if (base == rst_pkg::RESET_CAUSE_FLAGS_OFS) begin
                    prdata <= reset_cause_flags_reg;
                end else if (base == rst_pkg::NMI_OFS) begin
                    prdata <= nmi_reg;
                end else if (base != rst_pkg::SOFTWARE_RESET_TRIGGER_OFS) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    property p_zero_reload;
        @(posedge mclk) disable iff (!rstn)
        (cnt_start && !cnt_busy && nmi_reg[15:0] == 16'h0000) |=> ##1 system_master_reset;
    endproperty
    a_zero_reload: assert property (p_zero_reload) else $error("zero reload no reset");

    property p_por_flags;
        @(posedge mclk) disable iff (!rstn)
        power_on_event |=> reset_cause_flags_reg[1:0] == 2'b11 && !reset_cause_flags_reg[10];
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

    property p_wdt_flag;
        @(posedge mclk) disable iff (!rstn)
        watchdog_reset_source && !power_on_event |=> reset_cause_flags_reg[4];
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

    property p_cfg_reset;
        @(posedge mclk) disable iff (!rstn)
        config_mismatch_event |=> system_master_reset && reset_cause_flags_reg[9];
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("mismatch not merged");

    property p_key_general_nmi_flag;
        @(posedge mclk) disable iff (!rstn)
        key_hit && !nmi_reg[19] |=> nmi_reg[19] ##1 nmi_out;
    endproperty
    a_key_general_nmi_flag: assert property (p_key_general_nmi_flag) else $error("key did not raise nmi");

    property p_voltage_detect_nmi_flag;
        @(posedge mclk) disable iff (!rstn)
        voltage_detect_event |=> nmi_reg[18];
    endproperty
    a_voltage_detect_nmi_flag: assert property (p_voltage_detect_nmi_flag) else $error("voltage flag missing");

    property p_cf;
        @(posedge mclk) disable iff (!rstn)
        clock_fail_monitor |=> nmi_reg[17];
    endproperty
    a_cf: assert property (p_cf) else $error("clock fail flag missing");

    property p_ws;
        @(posedge mclk) disable iff (!rstn)
        sleep_watchdog_event |=> nmi_reg[16];
    endproperty
    a_ws: assert property (p_ws) else $error("sleep watchdog flag missing");

    property p_merge;
        @(posedge mclk) disable iff (!rstn)
        power_on_event || brownout_event || watchdog_reset_source |=> system_master_reset;
    endproperty
    a_merge: assert property (p_merge) else $error("reset source not merged");

    property p_pin_flag;
        @(posedge mclk) disable iff (!rstn)
        pin_fall && !power_on_event |=> system_master_reset && reset_cause_flags_reg[rst_pkg::B_PIN_RST];
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin reset not flagged");

    property p_sw_flag;
        @(posedge mclk) disable iff (!rstn)
        sw_reset_reg && !power_on_event |=> system_master_reset && reset_cause_flags_reg[rst_pkg::B_SW_RST];
    endproperty
    a_sw_flag: assert property (p_sw_flag) else $error("software reset not flagged");

    property p_locked_drop;
        @(posedge mclk) disable iff (!rstn)
        wr && base == rst_pkg::SOFTWARE_RESET_TRIGGER_OFS && unlock_reg != 2'b10 |=> !sw_reset_reg;
    endproperty
    a_locked_drop: assert property (p_locked_drop) else $error("locked trigger taken");

    property p_brownout;
        @(posedge mclk) disable iff (!rstn)
        brownout_event && !power_on_event |=> reset_cause_flags_reg[rst_pkg::B_BROWNOUT];
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out flag missing");

    property p_sleep_wake;
        @(posedge mclk) disable iff (!rstn)
        sleep_wake_event && !power_on_event |=> reset_cause_flags_reg[rst_pkg::B_SLEEP];
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep flag missing");

    property p_fire_flag;
        @(posedge mclk) disable iff (!rstn)
        fire && !power_on_event |=> system_master_reset && reset_cause_flags_reg[rst_pkg::B_WDT_RST];
    endproperty
    a_fire_flag: assert property (p_fire_flag) else $error("counted reset lost");

    // A cleared cause must not leave a late reset behind
    property p_count_abort;
        @(posedge mclk) disable iff (!rstn)
        cnt_busy && !cnt_pending |=> !fire;
    endproperty
    a_count_abort: assert property (p_count_abort) else $error("aborted count fired");

    property p_wdt_nmi;
        @(posedge mclk) disable iff (!rstn)
        watchdog_nmi_event |=> nmi_reg[rst_pkg::B_WDT_NMI];
    endproperty
    a_wdt_nmi: assert property (p_wdt_nmi) else $error("watchdog nmi flag missing");

    sequence s_sw_trigger;
        sw_nmi_wr && nmi_wr_val[rst_pkg::B_SW_NMI];
    endsequence

    property p_sw_nmi;
        @(posedge mclk) disable iff (!rstn)
        s_sw_trigger |=> !nmi_reg[rst_pkg::B_SW_NMI] ##1 nmi_out;
    endproperty
    a_sw_nmi: assert property (p_sw_nmi) else $error("software nmi missing");
endmodule

// ---- src/rst_pkg.sv ----
// Package of register map, field positions and reset values for the reset cause block
package rst_pkg;
    localparam logic [7:0]  RESET_CAUSE_FLAGS_OFS      = 8'h00;
    localparam logic [7:0]  NMI_OFS       = 8'h10;
    localparam logic [7:0]  SOFTWARE_RESET_TRIGGER_OFS     = 8'h20;
    localparam logic [7:0]  CLR_OFS       = 8'h04;
    localparam logic [7:0]  SET_OFS       = 8'h08;
    localparam logic [7:0]  INV_OFS       = 8'h0c;
    localparam int          B_DEEP_SLEEP  = 10;
    localparam int          B_CFG_MISM    = 9;
    localparam int          B_PIN_RST     = 7;
    localparam int          B_SW_RST      = 6;
    localparam int          B_WDT_RST     = 4;
    localparam int          B_SLEEP       = 3;
    localparam int          B_IDLE        = 2;
    localparam int          B_BROWNOUT    = 1;
    localparam int          B_POWER_ON    = 0;
    localparam int          B_WDT_NMI     = 24;
    localparam int          B_SW_NMI      = 23;
    localparam int          B_GEN_NMI     = 19;
    localparam int          B_VOLT_NMI    = 18;
    localparam int          B_CLK_FAIL    = 17;
    localparam int          B_SLEEP_WDT   = 16;
    localparam logic [31:0] RESET_CAUSE_FLAGS_MASK     = 32'h0000_06df;
    localparam logic [31:0] NMI_MASK      = 32'h018f_ffff;
    localparam logic [31:0] RESET_CAUSE_FLAGS_RESET    = 32'h0000_0003;
    localparam logic [31:0] NMI_RESET     = 32'h0000_0000;
    localparam logic [7:0]  NMI_KEY_VALUE = 8'h4e;
    localparam logic [31:0] UNLOCK_KEY1   = 32'h1234_5678;
    localparam logic [31:0] UNLOCK_KEY2   = 32'h8765_4321;
    localparam logic [31:0] RSV_VALUE     = 32'h0000_0000;
endpackage

// ---- src/nmi_reset_counter.sv ----
// NMI reset counter: reload on a qualifying NMI, count down, fire on zero
module nmi_reset_counter (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic        pending,
    input  wire logic [15:0] reload,
    output logic             fire,
    output logic             busy
);
    logic [15:0] count_reg;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            count_reg <= 16'h0000;
            busy      <= 1'b0;
            fire      <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (start && !busy) begin
                // Zero reload means no delay at all
                if (reload == 16'h0000) begin
                    fire <= 1'b1;
                end else begin
                    count_reg <= reload;
                    busy      <= 1'b1;
                end
            end else if (busy) begin
                // Cleared cause aborts the countdown
                if (!pending) begin
                    busy <= 1'b0;
                end else if (count_reg == 16'h0001) begin
                    busy <= 1'b0;
                    fire <= 1'b1;
                end else begin
                    count_reg <= count_reg - 16'h0001;
                end
            end
        end
    end
endmodule

// ---- verification/reset_source_model.sv ----
// Model of the on-chip reset and NMI sources driving the block
module reset_source_model (
    input  wire logic  mclk,
    output logic [11:0] events,
    output logic        master_clear_pin,
    output logic        nmi_key_write,
    output logic [7:0]  nmi_key_field
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        events           = 12'h000;
        master_clear_pin = 1'b1;
        nmi_key_write    = 1'b0;
        nmi_key_field    = 8'h00;
    end
    // One-cycle event from one source
    task automatic pulse(input int idx);
        @(posedge mclk);
        events <= 12'h001 << idx;
        @(posedge mclk);
        events <= 12'h000;
    endtask
    // Pin held low long enough to pass the two-flop sync
    task automatic press_pin();
        @(posedge mclk);
        master_clear_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        master_clear_pin <= 1'b1;
    endtask
    // Field shows the inverse of its last value once released
    task automatic key(input logic [7:0] v);
        @(posedge mclk);
        nmi_key_write <= 1'b1;
        nmi_key_field <= v;
        @(posedge mclk);
        nmi_key_write <= 1'b0;
        nmi_key_field <= ~v;
    endtask
endmodule

// ---- verification/tb_reset_cause_and_nmi_control.sv ----
// Self-checking bench for the reset cause and NMI control block
module tb_reset_cause_and_nmi_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         RLD  = 20;
    localparam logic [7:0] RCLR = rst_pkg::RESET_CAUSE_FLAGS_OFS + rst_pkg::CLR_OFS;
    localparam logic [7:0] NCLR = rst_pkg::NMI_OFS + rst_pkg::CLR_OFS;
    localparam logic [7:0] NSET = rst_pkg::NMI_OFS + rst_pkg::SET_OFS;
    localparam logic [7:0] NINV = rst_pkg::NMI_OFS + rst_pkg::INV_OFS;
    localparam int RBIT[6] = '{rst_pkg::B_BROWNOUT, rst_pkg::B_WDT_RST, rst_pkg::B_CFG_MISM,
                               rst_pkg::B_DEEP_SLEEP, rst_pkg::B_SLEEP, rst_pkg::B_IDLE};
    localparam int NBIT[5] = '{rst_pkg::B_WDT_NMI, rst_pkg::B_SLEEP_WDT, rst_pkg::B_GEN_NMI,
                               rst_pkg::B_VOLT_NMI, rst_pkg::B_CLK_FAIL};
    logic        mclk    = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] fuses   = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] ev;
    logic        pin_n;
    logic        key_wr;
    logic [7:0]  key_val;
    logic        sys_rst;
    logic        nmi;
    logic [31:0] rd;
    logic        serr;
    int          err_count    = 0;
    int          total_checks = 0;
    int          rst_cnt      = 0;
    int          nmi_cnt      = 0;
    int          base;
    int          cyc;

    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        if (sys_rst === 1'b1) rst_cnt++;
        if (nmi === 1'b1) nmi_cnt++;
    end

    reset_source_model i_src (.mclk(mclk), .events(ev), .master_clear_pin(pin_n),
        .nmi_key_write(key_wr), .nmi_key_field(key_val));

    reset_cause_and_nmi_control i_dut (.mclk(mclk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_on_event(ev[0]),
        .brownout_event(ev[1]), .master_clear_pin(pin_n), .watchdog_reset_source(ev[2]),
        .config_mismatch_event(ev[3]), .deep_sleep_event(ev[4]), .sleep_wake_event(ev[5]),
        .idle_wake_event(ev[6]), .watchdog_nmi_event(ev[7]), .sleep_watchdog_event(ev[8]),
        .general_nmi_event(ev[9]), .voltage_detect_event(ev[10]),
        .clock_fail_monitor(ev[11]), .nmi_key_write(key_wr), .nmi_key_field(key_val),
        .configuration_fuses(fuses), .system_master_reset(sys_rst), .nmi_out(nmi));

    task automatic finish_test();
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        // Idle edge first, so no signal is driven twice in one time step
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            $display("ERROR %0t: no pready", $time);
            finish_test();
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        apb(1'b0, rst_pkg::RESET_CAUSE_FLAGS_OFS, 32'h0);
        chk(rd, rst_pkg::RESET_CAUSE_FLAGS_RESET);
        apb(1'b0, rst_pkg::NMI_OFS, 32'h0);
        chk(rd, rst_pkg::NMI_RESET);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, serr}, 32'h1);
        apb(1'b1, rst_pkg::RESET_CAUSE_FLAGS_OFS, 32'hffff_ffff);
        apb(1'b0, rst_pkg::RESET_CAUSE_FLAGS_OFS, 32'h0);
        chk(rd, rst_pkg::RESET_CAUSE_FLAGS_MASK);
        apb(1'b1, RCLR, 32'hffff_ffff);
        apb(1'b0, rst_pkg::RESET_CAUSE_FLAGS_OFS, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            base = rst_cnt;
            i_src.pulse(i + 1);
            settle(3);
            if (i < 3) chk(32'(rst_cnt - base), 32'h1);
            apb(1'b0, rst_pkg::RESET_CAUSE_FLAGS_OFS, 32'h0);
            chk(rd, 32'h1 << RBIT[i]);
            apb(1'b1, RCLR, 32'hffff_ffff);
        end
        base = rst_cnt;
        i_src.press_pin();
        settle(6);
        chk(32'(rst_cnt - base), 32'h1);
        apb(1'b0, rst_pkg::RESET_CAUSE_FLAGS_OFS, 32'h0);
        chk(rd, 32'h1 << rst_pkg::B_PIN_RST);
        apb(1'b1, RCLR, 32'hffff_ffff);
        // Trigger without the unlock keys must be dropped
        base = rst_cnt;
        apb(1'b1, rst_pkg::SOFTWARE_RESET_TRIGGER_OFS, 32'h1);
        settle(3);
        chk(32'(rst_cnt - base), 32'h0);
        apb(1'b1, rst_pkg::SOFTWARE_RESET_TRIGGER_OFS, rst_pkg::UNLOCK_KEY1);
        apb(1'b1, rst_pkg::SOFTWARE_RESET_TRIGGER_OFS, rst_pkg::UNLOCK_KEY2);
        apb(1'b1, rst_pkg::SOFTWARE_RESET_TRIGGER_OFS, 32'h1);
        settle(3);
        chk(32'(rst_cnt - base), 32'h1);
        apb(1'b0, rst_pkg::RESET_CAUSE_FLAGS_OFS, 32'h0);
        chk(rd, 32'h1 << rst_pkg::B_SW_RST);
        for (int i = 0; i < 5; i++) begin
            base = nmi_cnt;
            i_src.pulse(i + 7);
            settle(3);
            chk(32'(nmi_cnt - base), 32'h1);
            apb(1'b0, rst_pkg::NMI_OFS, 32'h0);
            chk(rd, 32'h1 << NBIT[i]);
            apb(1'b1, NCLR, 32'h01ff_0000);
            if (i != 3) begin
                base = nmi_cnt;
                apb(1'b1, NSET, 32'h1 << NBIT[i]);
                settle(3);
                chk(32'(nmi_cnt - base), 32'h1);
                apb(1'b1, NCLR, 32'h01ff_0000);
            end
        end
        i_src.key(rst_pkg::NMI_KEY_VALUE);
        settle(2);
        apb(1'b0, rst_pkg::NMI_OFS, 32'h0);
        chk(rd, 32'h1 << rst_pkg::B_GEN_NMI);
        apb(1'b1, NCLR, 32'h01ff_0000);
        i_src.key(8'h4d);
        settle(2);
        apb(1'b0, rst_pkg::NMI_OFS, 32'h0);
        chk(rd, 32'h0);
        base = nmi_cnt;
        apb(1'b1, NSET, 32'h1 << rst_pkg::B_SW_NMI);
        settle(3);
        chk(32'(nmi_cnt - base), 32'h1);
        apb(1'b0, rst_pkg::NMI_OFS, 32'h0);
        chk(rd, 32'h0);
        base = nmi_cnt;
        apb(1'b1, rst_pkg::NMI_OFS, 32'h0);
        settle(3);
        chk(32'(nmi_cnt - base), 32'h0);
        // Counted reset is enabled by fuse bit 0
        fuses <= 32'h0000_0001;
        apb(1'b1, rst_pkg::NMI_OFS, 32'h0000_00f0);
        apb(1'b1, NINV, 32'h0000_00ff);
        apb(1'b0, rst_pkg::NMI_OFS, 32'h0);
        chk(rd, 32'h0000_000f);
        apb(1'b1, rst_pkg::NMI_OFS, 32'(RLD));
        i_src.pulse(7);
        cyc = 0;
        do begin
            @(posedge mclk);
            cyc++;
        end while (sys_rst !== 1'b1 && cyc < 100);
        // Counter load, output flop and the loop sampling before the edge's update add three edges
        chk(32'(cyc), 32'(RLD + 3));
        apb(1'b1, NCLR, 32'h01ff_0000);
        settle(3);
        base = rst_cnt;
        i_src.pulse(7);
        apb(1'b1, NCLR, 32'h0100_0000);
        settle(RLD + 10);
        chk(32'(rst_cnt - base), 32'h0);
        apb(1'b1, rst_pkg::NMI_OFS, 32'h0);
        base = rst_cnt;
        apb(1'b1, NSET, 32'h1 << rst_pkg::B_CLK_FAIL);
        settle(4);
        chk(32'(rst_cnt != base), 32'h1);
        apb(1'b1, NCLR, 32'h01ff_0000);
        i_src.pulse(0);
        settle(3);
        apb(1'b0, rst_pkg::RESET_CAUSE_FLAGS_OFS, 32'h0);
        chk(rd, rst_pkg::RESET_CAUSE_FLAGS_RESET);
        finish_test();
    end

    initial begin
        #4000000;
        err_count++;
        $display("ERROR %0t: run timed out", $time);
        finish_test();
    end
endmodule
